/* File: verilog/ssdp_defines.svh */
// Constants for the synchronous serial data port
// Function
// - Packet format field set to one selects synchronous serial mode, bypassing FIFOs.
// - Device drives the bit clock; host moves bits relative to it.
// - Transmit data enters on pin zero, which becomes input while transmitting.
// - Receive data leaves on whichever pin selects the serial data function.
// - Sync mode field enables preamble and sync insertion and detection.
// - With sync handling on, device adds and finds sync; host sees payload.
`ifndef SSDP_DEFINES_SVH
`define SSDP_DEFINES_SVH
// Register indices, byte address is four times the index
`define SSDP_IDX_PIN_TWO 9'h000
`define SSDP_IDX_PIN_ONE 9'h001
`define SSDP_IDX_PIN_ZERO 9'h002
`define SSDP_IDX_PKT_CTRL 9'h008
`define SSDP_IDX_MODEM_CFG 9'h012
`define SSDP_IDX_CONTROL 9'h040
`define SSDP_IDX_STATUS 9'h041
// Reset values
`define SSDP_RST_PIN_CFG 8'h00
`define SSDP_RST_PKT_CTRL 8'h00
`define SSDP_RST_MODEM_CFG 8'h00
`define SSDP_RST_CONTROL 8'h00
// Field values and positions
`define SSDP_FMT_SERIAL 2'h1
`define SSDP_MANCH_BIT 3
`define SSDP_FS_DATA 6'h01
`define SSDP_FS_CLOCK 6'h02
`define SSDP_CTRL_TX_BIT 0
`define SSDP_CTRL_RX_BIT 1
`define SSDP_STAT_SYNC_BIT 7
// Framing
`define SSDP_PREAMBLE_BITS 5'h10
`define SSDP_SYNC_WORD 16'hB53C
// Bit clock timing
`define SSDP_SYS_PERIOD_NS 100
`define SSDP_BIT_PERIOD_NS 800
`define SSDP_HALF_CYCLES (`SSDP_BIT_PERIOD_NS / (2 * `SSDP_SYS_PERIOD_NS))
// Bus answers
`define SSDP_RESP_OKAY 2'h0
`define SSDP_RESP_SLVERR 2'h2
`endif

/* File: verilog/ssdp_pkg.sv */
// Types for the synchronous serial data port
package ssdp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PREAMBLE = 3'h1,
    ST_SYNC = 3'h2,
    ST_TX_PAYLOAD = 3'h3,
    ST_RX_HUNT = 3'h4,
    ST_RX_PAYLOAD = 3'h5
  } ssdp_state_type;
endpackage : ssdp_pkg

/* File: verilog/ssdp_bitclk.sv */
// Bit clock divider with edge pulses
`include "ssdp_defines.svh"
module ssdp_bitclk (
  // System
  input wire logic clk,
  input wire logic reset,
  // Control and outputs
  input wire logic run,
  output logic level,
  output logic rise,
  output logic fall
);
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic next_level;
  logic next_rise;
  logic next_fall;

  // Half period count; stopping clears phase so each run starts low
  always_comb begin
    next_cnt = cnt + 3'h1;
    next_level = level;
    next_rise = 1'b0;
    next_fall = 1'b0;
    if (!run) begin
      next_cnt = 3'h0;
      next_level = 1'b0;
    end else if (cnt == 3'(`SSDP_HALF_CYCLES - 1)) begin
      next_cnt = 3'h0;
      next_level = !level;
      next_rise = !level;
      next_fall = level;
    end
  end

  // Registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt <= 3'h0;
      level <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      cnt <= next_cnt;
      level <= next_level;
      rise <= next_rise;
      fall <= next_fall;
    end
  end
endmodule : ssdp_bitclk

/* File: verilog/ssdp_top.sv */
// Synchronous serial data port with AXI4-Lite registers
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`include "ssdp_defines.svh"
module ssdp_top (
  // System
  input wire logic SYS_CLK,
  input wire logic RESET,
  // AXI4-Lite write
  input wire logic [8:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read
  input wire logic [8:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // General purpose pins
  input wire logic GP0_IN,
  output logic GP0_OUT,
  output logic GP0_OE_N,
  output logic GP1_OUT,
  output logic GP2_OUT,
  // Modem air side
  input wire logic AIR_RX_DATA,
  output logic AIR_TX_DATA,
  output logic AIR_TX_STROBE
);
  // Word index to register select, 7 means unmapped
  function automatic logic [2:0] reg_sel(input logic [8:0] addr);
    logic [6:0] idx;
    idx = addr[8:2];
    if (addr[1:0] != 2'h0) reg_sel = 3'h7;
    else if ({2'h0, idx} == `SSDP_IDX_PIN_TWO) reg_sel = 3'h0;
    else if ({2'h0, idx} == `SSDP_IDX_PIN_ONE) reg_sel = 3'h1;
    else if ({2'h0, idx} == `SSDP_IDX_PIN_ZERO) reg_sel = 3'h2;
    else if ({2'h0, idx} == `SSDP_IDX_PKT_CTRL) reg_sel = 3'h3;
    else if ({2'h0, idx} == `SSDP_IDX_MODEM_CFG) reg_sel = 3'h4;
    else if ({2'h0, idx} == `SSDP_IDX_CONTROL) reg_sel = 3'h5;
    else if ({2'h0, idx} == `SSDP_IDX_STATUS) reg_sel = 3'h6;
    else reg_sel = 3'h7;
  endfunction : reg_sel

  // Level a pin shows for its function select
  function automatic logic pin_drive(input logic [5:0] fs, input logic clk, input logic dat);
    pin_drive = (fs == `SSDP_FS_DATA) ? dat : ((fs == `SSDP_FS_CLOCK) ? clk : 1'b0);
  endfunction : pin_drive

  // Register file and bus state
  logic [7:0] pin_two_config_reg, pin_one_config_reg, pin_zero_config_reg;
  logic [7:0] packet_control_reg_low, modem_config_reg_two, control_reg;
  logic aw_held, w_held, sync_seen;
  logic [2:0] aw_sel;
  logic [7:0] w_byte;
  logic w_lane;
  logic [7:0] next_pin_two, next_pin_one, next_pin_zero, next_pkt, next_modem, next_ctrl;
  logic next_aw_held, next_w_held, next_bvalid, next_rvalid, next_sync_seen;
  logic [2:0] next_aw_sel;
  logic [7:0] next_w_byte;
  logic next_w_lane;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic do_write, sync_hit;
  logic [2:0] rd_sel;
  // Core state
  ssdp_pkg::ssdp_state_type state, next_state;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [15:0] rx_shift, next_rx_shift;
  logic data_out, next_data_out, link_clk, next_link_clk;
  logic next_air_data, next_air_strobe, next_gp0_oe_n;
  logic gp0_meta, gp0_s;
  logic rise_p, fall_p;
  // Sync word as a vector so one bit can be picked per strobe
  localparam logic [15:0] sync_word = `SSDP_SYNC_WORD;
  logic serial_mode, sync_on, tx_en, rx_en, manch_bad;

  assign serial_mode = packet_control_reg_low[1:0] == `SSDP_FMT_SERIAL;
  assign sync_on = modem_config_reg_two[2:0] != 3'h0;
  assign tx_en = control_reg[`SSDP_CTRL_TX_BIT];
  assign rx_en = control_reg[`SSDP_CTRL_RX_BIT];
  // Shown only; the host owns line coding choice
  assign manch_bad = serial_mode && modem_config_reg_two[`SSDP_MANCH_BIT];
  assign do_write = aw_held && w_held && !S_AXI_BVALID;
  assign rd_sel = reg_sel(S_AXI_ARADDR);

  // Bus slave next values; address and data may come in either order
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_sel = aw_sel;
    next_w_byte = w_byte;
    next_w_lane = w_lane;
    next_bvalid = S_AXI_BVALID && !S_AXI_BREADY;
    next_bresp = S_AXI_BRESP;
    next_rvalid = S_AXI_RVALID && !S_AXI_RREADY;
    next_rresp = S_AXI_RRESP;
    next_rdata = S_AXI_RDATA;
    next_pin_two = pin_two_config_reg;
    next_pin_one = pin_one_config_reg;
    next_pin_zero = pin_zero_config_reg;
    next_pkt = packet_control_reg_low;
    next_modem = modem_config_reg_two;
    next_ctrl = control_reg;
    next_sync_seen = sync_seen;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      next_aw_held = 1'b1;
      next_aw_sel = reg_sel(S_AXI_AWADDR);
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      next_w_held = 1'b1;
      next_w_byte = S_AXI_WDATA[7:0];
      next_w_lane = S_AXI_WSTRB[0];
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (aw_sel == 3'h7) ? `SSDP_RESP_SLVERR : `SSDP_RESP_OKAY;
      if (w_lane) begin
        unique case (aw_sel)
          3'h0: next_pin_two = w_byte;
          3'h1: next_pin_one = w_byte;
          3'h2: next_pin_zero = w_byte;
          3'h3: next_pkt = w_byte;
          3'h4: next_modem = w_byte;
          3'h5: next_ctrl = w_byte;
          3'h6: if (w_byte[`SSDP_STAT_SYNC_BIT]) next_sync_seen = 1'b0;
          default: next_w_lane = w_lane;
        endcase
      end
    end
    // Detection wins over a clear in the same cycle
    if (sync_hit) next_sync_seen = 1'b1;
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      next_rvalid = 1'b1;
      next_rresp = (rd_sel == 3'h7) ? `SSDP_RESP_SLVERR : `SSDP_RESP_OKAY;
      unique case (rd_sel)
        3'h0: next_rdata = {24'h00_0000, pin_two_config_reg};
        3'h1: next_rdata = {24'h00_0000, pin_one_config_reg};
        3'h2: next_rdata = {24'h00_0000, pin_zero_config_reg};
        3'h3: next_rdata = {24'h00_0000, packet_control_reg_low};
        3'h4: next_rdata = {24'h00_0000, modem_config_reg_two};
        3'h5: next_rdata = {24'h00_0000, control_reg};
        3'h6: next_rdata = {24'h00_0000, sync_seen, manch_bad, 3'h0, state};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Bus registers
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_sel <= 3'h0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'h0;
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RRESP <= 2'h0;
      S_AXI_RDATA <= 32'h0000_0000;
      pin_two_config_reg <= `SSDP_RST_PIN_CFG;
      pin_one_config_reg <= `SSDP_RST_PIN_CFG;
      pin_zero_config_reg <= `SSDP_RST_PIN_CFG;
      packet_control_reg_low <= `SSDP_RST_PKT_CTRL;
      modem_config_reg_two <= `SSDP_RST_MODEM_CFG;
      control_reg <= `SSDP_RST_CONTROL;
      sync_seen <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_sel <= next_aw_sel;
      w_byte <= next_w_byte;
      w_lane <= next_w_lane;
      S_AXI_AWREADY <= !next_aw_held;
      S_AXI_WREADY <= !next_w_held;
      S_AXI_BVALID <= next_bvalid;
      S_AXI_BRESP <= next_bresp;
      S_AXI_ARREADY <= !next_rvalid;
      S_AXI_RVALID <= next_rvalid;
      S_AXI_RRESP <= next_rresp;
      S_AXI_RDATA <= next_rdata;
      pin_two_config_reg <= next_pin_two;
      pin_one_config_reg <= next_pin_one;
      pin_zero_config_reg <= next_pin_zero;
      packet_control_reg_low <= next_pkt;
      modem_config_reg_two <= next_modem;
      control_reg <= next_ctrl;
      sync_seen <= next_sync_seen;
    end
  end

  // Bit clock runs only while a transfer is under way
  ssdp_bitclk u_bitclk (
    .clk(SYS_CLK),
    .reset(RESET),
    .run(state != ssdp_pkg::ST_IDLE),
    .level(),
    .rise(rise_p),
    .fall(fall_p)
  );

  assign sync_hit = state == ssdp_pkg::ST_RX_HUNT && rise_p
    && {rx_shift[14:0], AIR_RX_DATA} == `SSDP_SYNC_WORD;

  // Core sequencer; transmit wins when both directions are enabled
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_rx_shift = rx_shift;
    next_data_out = data_out;
    next_air_data = AIR_TX_DATA;
    next_air_strobe = 1'b0;
    unique case (state)
      ssdp_pkg::ST_IDLE: begin
        next_bit_cnt = 5'h00;
        next_data_out = 1'b0;
        if (serial_mode && tx_en) begin
          next_state = sync_on ? ssdp_pkg::ST_PREAMBLE : ssdp_pkg::ST_TX_PAYLOAD;
        end else if (serial_mode && rx_en) begin
          next_state = sync_on ? ssdp_pkg::ST_RX_HUNT : ssdp_pkg::ST_RX_PAYLOAD;
        end
      end
      ssdp_pkg::ST_PREAMBLE: if (rise_p) begin
        next_air_data = !bit_cnt[0];
        next_air_strobe = 1'b1;
        next_bit_cnt = bit_cnt + 5'h01;
        if (bit_cnt == `SSDP_PREAMBLE_BITS - 5'h01) begin
          next_state = ssdp_pkg::ST_SYNC;
          next_bit_cnt = 5'h00;
        end
      end
      ssdp_pkg::ST_SYNC: if (rise_p) begin
        next_air_data = sync_word[4'hF - bit_cnt[3:0]];
        next_air_strobe = 1'b1;
        next_bit_cnt = bit_cnt + 5'h01;
        if (bit_cnt[3:0] == 4'hF) next_state = ssdp_pkg::ST_TX_PAYLOAD;
      end
      ssdp_pkg::ST_TX_PAYLOAD: if (rise_p) begin
        next_air_data = gp0_s;
        next_air_strobe = 1'b1;
      end
      ssdp_pkg::ST_RX_HUNT: begin
        if (rise_p) next_rx_shift = {rx_shift[14:0], AIR_RX_DATA};
        if (sync_hit) next_state = ssdp_pkg::ST_RX_PAYLOAD;
      end
      ssdp_pkg::ST_RX_PAYLOAD: if (fall_p) begin
        next_data_out = AIR_RX_DATA;
      end
    endcase
    // Leaving serial mode or dropping the enable aborts the transfer
    if (state != ssdp_pkg::ST_IDLE && (!serial_mode || !(tx_en || rx_en)
        || (state >= ssdp_pkg::ST_RX_HUNT && tx_en)
        || (state < ssdp_pkg::ST_RX_HUNT && !tx_en))) begin
      next_state = ssdp_pkg::ST_IDLE;
    end
    // Clock shows only while payload bits move; it starts at a rise pulse so
    // a half period left over from framing never shows a stray edge to the host
    next_link_clk = (state == ssdp_pkg::ST_TX_PAYLOAD || state == ssdp_pkg::ST_RX_PAYLOAD)
      && (rise_p || (link_clk && !fall_p));
    next_gp0_oe_n = (state == ssdp_pkg::ST_TX_PAYLOAD || state == ssdp_pkg::ST_PREAMBLE
      || state == ssdp_pkg::ST_SYNC || tx_en)
      || !(pin_zero_config_reg[5:0] == `SSDP_FS_DATA
      || pin_zero_config_reg[5:0] == `SSDP_FS_CLOCK);
  end

  // Core registers; pin zero input passes two flops first
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      state <= ssdp_pkg::ST_IDLE;
      bit_cnt <= 5'h00;
      rx_shift <= 16'h0000;
      data_out <= 1'b0;
      link_clk <= 1'b0;
      gp0_meta <= 1'b0;
      gp0_s <= 1'b0;
      AIR_TX_DATA <= 1'b0;
      AIR_TX_STROBE <= 1'b0;
      GP0_OUT <= 1'b0;
      GP0_OE_N <= 1'b1;
      GP1_OUT <= 1'b0;
      GP2_OUT <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      rx_shift <= next_rx_shift;
      data_out <= next_data_out;
      link_clk <= next_link_clk;
      gp0_meta <= GP0_IN;
      gp0_s <= gp0_meta;
      AIR_TX_DATA <= next_air_data;
      AIR_TX_STROBE <= next_air_strobe;
      GP0_OUT <= pin_drive(pin_zero_config_reg[5:0], next_link_clk, next_data_out);
      GP0_OE_N <= next_gp0_oe_n;
      GP1_OUT <= pin_drive(pin_one_config_reg[5:0], next_link_clk, next_data_out);
      GP2_OUT <= pin_drive(pin_two_config_reg[5:0], next_link_clk, next_data_out);
    end
  end

  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  a_serial_tx_entry: assert property (state == ssdp_pkg::ST_IDLE && serial_mode && tx_en
    && !sync_on |=> state == ssdp_pkg::ST_TX_PAYLOAD) else $error("tx entry missed");
  a_serial_off_idle: assert property (!serial_mode ##1 !serial_mode
    |-> state == ssdp_pkg::ST_IDLE) else $error("active outside serial mode");
  a_pin_zero_input: assert property (state == ssdp_pkg::ST_TX_PAYLOAD |=> GP0_OE_N)
    else $error("pin zero driven in tx");
  a_route_pin_one: assert property (pin_one_config_reg[5:0] == `SSDP_FS_DATA
    |=> GP1_OUT == data_out) else $error("pin one not data");
  a_clock_pin_two: assert property (pin_two_config_reg[5:0] == `SSDP_FS_CLOCK
    |=> GP2_OUT == link_clk) else $error("pin two not clock");
  a_preamble_len: assert property (state == ssdp_pkg::ST_PREAMBLE && rise_p && tx_en
    && serial_mode && bit_cnt == 5'h0F |=> state == ssdp_pkg::ST_SYNC)
    else $error("preamble length wrong");
  a_rx_hunt_entry: assert property (state == ssdp_pkg::ST_IDLE && serial_mode && rx_en
    && !tx_en && sync_on |=> state == ssdp_pkg::ST_RX_HUNT) else $error("no hunt");
  a_tx_on_rise: assert property (AIR_TX_STROBE && $past(state) == ssdp_pkg::ST_TX_PAYLOAD
    |-> $past(rise_p) && AIR_TX_DATA == $past(gp0_s)) else $error("tx sample");
  a_rx_on_fall: assert property ($changed(data_out) && state == ssdp_pkg::ST_RX_PAYLOAD
    |-> $past(fall_p)) else $error("rx changed off fall");
  a_clock_payload: assert property (link_clk |-> $past(state) == ssdp_pkg::ST_TX_PAYLOAD
    || $past(state) == ssdp_pkg::ST_RX_PAYLOAD) else $error("clock outside payload");
  c_tx_payload: cover property (state == ssdp_pkg::ST_TX_PAYLOAD && AIR_TX_STROBE);
  c_sync_found: cover property (sync_hit);
  c_rx_payload: cover property (state == ssdp_pkg::ST_RX_PAYLOAD && fall_p);
endmodule : ssdp_top

/* File: test/ssdp_host_model.sv */
// Host controller model on the far side of the serial link
module ssdp_host_model (
  // System
  input wire logic clk,
  // Link pins
  input wire logic link_clk,
  input wire logic rx_pin,
  input wire logic dev_out,
  input wire logic dev_oe_n,
  output logic pin_zero,
  // Bench control
  input wire logic tx_arm,
  input wire logic slow,
  input wire logic [15:0] tx_word
);
  logic link_q = 1'b0;
  logic rise_q = 1'b0;
  logic idle_pat = 1'b0;
  logic [15:0] tx_shift = 16'h0000;
  logic [31:0] rx_hist = 32'h0000_0000;
  // Edge finding; transmit setup has no spare cycle, so slow mode only
  // samples receive data one cycle late to use up the hold margin
  always_ff @(posedge clk) begin
    link_q <= link_clk;
    rise_q <= !link_q && link_clk;
    idle_pat <= ~idle_pat;
    if (!tx_arm) begin
      tx_shift <= tx_word;
    end else if (link_q && !link_clk) begin
      tx_shift <= {tx_shift[14:0], 1'b0};
    end
    if (slow ? rise_q : (!link_q && link_clk)) begin
      rx_hist <= {rx_hist[30:0], rx_pin};
    end
  end
  // Wire level; a released pin shows a changing pattern, not a held value
  always_comb begin
    if (!dev_oe_n) begin
      pin_zero = dev_out;
    end else if (tx_arm) begin
      pin_zero = tx_shift[15];
    end else begin
      pin_zero = idle_pat;
    end
  end
endmodule : ssdp_host_model

/* File: test/test_sync_serial_data_port.sv */
// Self-checking bench for the synchronous serial data port
`include "ssdp_defines.svh"
module test_sync_serial_data_port;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [8:0] addr;
    logic [3:0] strb;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [1:0] resp;
  } ssdp_row_type;
  localparam logic [1:0] ok_resp = `SSDP_RESP_OKAY;
  localparam logic [1:0] err_resp = `SSDP_RESP_SLVERR;
  // Register rows; a zero strobe must store nothing
  ssdp_row_type rows [9] = '{
    '{9'h000, 4'h0, 8'h11, 8'h00, ok_resp},
    '{9'h000, 4'hF, 8'h2A, 8'h2A, ok_resp},
    '{9'h004, 4'hF, 8'h15, 8'h15, ok_resp},
    '{9'h008, 4'hF, 8'h01, 8'h01, ok_resp},
    '{9'h020, 4'hF, 8'h03, 8'h03, ok_resp},
    '{9'h048, 4'hF, 8'h0F, 8'h0F, ok_resp},
    '{9'h100, 4'hF, 8'h00, 8'h00, ok_resp},
    '{9'h0C0, 4'hF, 8'hFF, 8'h00, err_resp},
    '{9'h002, 4'hF, 8'hFF, 8'h00, err_resp}
  };
  // Bench-driven inputs
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [8:0] awaddr = 9'h000;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [8:0] araddr = 9'h000;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic air_rx = 1'b0;
  logic tx_arm = 1'b0;
  logic slow = 1'b0;
  logic [15:0] tx_word = 16'hC93A;
  // Design outputs
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic gp0_pin, gp0_out, gp0_oe_n, gp1_out, gp2_out, air_tx, air_stb;
  int bad_count = 0;
  int samples_checked = 0;

  // Clock at 10 MHz
  always #50 sys_clk = ~sys_clk;

  ssdp_top dut (
    .SYS_CLK(sys_clk), .RESET(reset),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .GP0_IN(gp0_pin), .GP0_OUT(gp0_out), .GP0_OE_N(gp0_oe_n),
    .GP1_OUT(gp1_out), .GP2_OUT(gp2_out),
    .AIR_RX_DATA(air_rx), .AIR_TX_DATA(air_tx), .AIR_TX_STROBE(air_stb)
  );

  // Pin one carries the bit clock, pin two the receive data
  ssdp_host_model host (
    .clk(sys_clk), .link_clk(gp1_out), .rx_pin(gp2_out),
    .dev_out(gp0_out), .dev_oe_n(gp0_oe_n), .pin_zero(gp0_pin),
    .tx_arm(tx_arm), .slow(slow), .tx_word(tx_word)
  );

  task automatic note_bad(input string what);
    bad_count++;
    $display("mismatch at %0t: %s", $time, what);
  endtask : note_bad

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) note_bad(what);
  endtask : check_word

  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
    samples_checked++;
    if (got !== exp) note_bad(what);
  endtask : check_resp

  task automatic check_stream(input logic [47:0] got, input logic [47:0] exp, input string what);
    samples_checked++;
    if (got !== exp) note_bad(what);
  endtask : check_stream

  // Write: address and data offered together, each dropped once taken
  task automatic axi_write(input logic [8:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    int n = 0;
    @(posedge sys_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    if (!bvalid) note_bad("write answer timed out");
    r = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [8:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    if (!rvalid) note_bad("read answer timed out");
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read

  // Transmit run: set up, collect strobed bits, then abort mid-stream
  task automatic run_tx(input logic [7:0] mode, input int nbits, input logic [47:0] exp);
    logic [47:0] got = '0;
    int n = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic [1:0] rs;
    axi_write(9'h000, 32'h0000_0001, 4'hF, rs);
    axi_write(9'h004, 32'h0000_0002, 4'hF, rs);
    axi_write(9'h008, 32'h0000_0001, 4'hF, rs);
    axi_write(9'h020, 32'h0000_0001, 4'hF, rs);
    axi_write(9'h048, {24'h00_0000, mode}, 4'hF, rs);
    tx_arm <= 1'b1;
    axi_write(9'h100, 32'h0000_0001, 4'hF, rs);
    while (n < nbits && cyc < 2000) begin
      @(posedge sys_clk);
      cyc++;
      if (air_stb) begin
        got = {got[46:0], air_tx};
        n++;
      end
    end
    check_stream(got, exp, "transmitted bits");
    check_word(32'(gp0_oe_n), 32'h0000_0001, "pin zero not input");
    axi_read(9'h104, rd, rs);
    check_word(32'(rd[2:0]), 32'h0000_0003, "tx state");
    axi_write(9'h100, 32'h0000_0000, 4'hF, rs);
    tx_arm <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check_word(32'(gp1_out), 32'h0000_0000, "bit clock not idle");
  endtask : run_tx

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // Hang guard, well beyond the roughly 1200 cycles the tests need
  initial begin
    #3_000_000;
    note_bad("watchdog expired");
    final_report();
  end

  initial begin : main
    logic [31:0] rd;
    logic [1:0] rs;
    int hits;
    int found;
    logic [47:0] air;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    axi_read(9'h104, rd, rs);
    check_word(rd, 32'h0000_0000, "status after reset");
    foreach (rows[i]) begin
      axi_read(rows[i].addr, rd, rs);
      check_word(rd, 32'h0000_0000, "reset value");
      axi_write(rows[i].addr, {24'h00_0000, rows[i].wdata}, rows[i].strb, rs);
      check_resp(rs, rows[i].resp, "write answer");
      axi_read(rows[i].addr, rd, rs);
      check_word(rd, {24'h00_0000, rows[i].rdata}, "read back");
      check_resp(rs, rows[i].resp, "read answer");
    end
    check_word(32'(gp0_oe_n), 32'h0000_0000, "pin zero not driven");
    $display("test registers done");
    run_tx(8'h00, 16, {32'h0000_0000, tx_word});
    $display("test tx without sync done");
    slow <= 1'b1;
    run_tx(8'h01, 48, {16'hAAAA, `SSDP_SYNC_WORD, tx_word});
    $display("test tx with sync done");
    // Serial mode off: enabling transmit must move nothing
    axi_write(9'h020, 32'h0000_0000, 4'hF, rs);
    axi_write(9'h100, 32'h0000_0001, 4'hF, rs);
    hits = 0;
    repeat (60) begin
      @(posedge sys_clk);
      if (air_stb || gp1_out) hits++;
    end
    check_word(32'(hits), 32'h0000_0000, "activity outside serial mode");
    axi_write(9'h100, 32'h0000_0000, 4'hF, rs);
    $display("test mode gate done");
    // Receive with sync hunt on; air bits held a whole bit period
    axi_write(9'h020, 32'h0000_0001, 4'hF, rs);
    axi_write(9'h100, 32'h0000_0002, 4'hF, rs);
    air = {8'h00, `SSDP_SYNC_WORD, 8'hC5, 16'h0000};
    hits = 0;
    for (int i = 47; i >= 0; i--) begin
      air_rx <= air[i];
      repeat (8) begin
        @(posedge sys_clk);
        if (gp0_out !== gp2_out) hits++;
      end
    end
    check_word(32'(hits), 32'h0000_0000, "pin zero data differs");
    axi_read(9'h104, rd, rs);
    check_word(32'(rd[7]), 32'h0000_0001, "sync not seen");
    check_word(32'(rd[2:0]), 32'h0000_0005, "rx state");
    found = 0;
    for (int i = 0; i <= 24; i++) begin
      if (host.rx_hist[i +: 8] === 8'hC5) found = 1;
    end
    check_word(32'(found), 32'h0000_0001, "payload on data pin");
    axi_write(9'h104, 32'h0000_0080, 4'hF, rs);
    axi_read(9'h104, rd, rs);
    check_word(32'(rd[7]), 32'h0000_0000, "sync flag not cleared");
    axi_write(9'h100, 32'h0000_0000, 4'hF, rs);
    $display("test rx with sync done");
    final_report();
  end
endmodule : test_sync_serial_data_port
